/* File: gsv_pkg.sv */
package gsv_pkg;

  // Register offsets
  localparam logic [7:0] GSV_ROW_DIR_OFS   = 8'h34;
  localparam logic [7:0] GSV_COL_DIR_OFS   = 8'h35;
  localparam logic [7:0] GSV_ROW_MODE_OFS  = 8'h36;
  localparam logic [7:0] GSV_COL_MODE_OFS  = 8'h37;
  localparam logic [7:0] GSV_ROW_SUP_OFS   = 8'h38;
  localparam logic [7:0] GSV_COL_SUP_OFS   = 8'h39;
  localparam logic [7:0] GSV_ROW_VAL_OFS   = 8'h3a;
  localparam logic [7:0] GSV_COL_VAL_OFS   = 8'h3b;
  localparam logic [7:0] GSV_PAIR_EN_OFS   = 8'h3c;

  // Reset values
  localparam logic [7:0] GSV_ROW_DIR_RST   = 8'h00;
  localparam logic [7:0] GSV_COL_DIR_RST   = 8'h00;
  localparam logic [7:0] GSV_ROW_MODE_RST  = 8'hff;
  localparam logic [7:0] GSV_COL_MODE_RST  = 8'h0f;
  localparam logic [7:0] GSV_ROW_SUP_RST   = 8'h00;
  localparam logic [7:0] GSV_COL_SUP_RST   = 8'h00;
  localparam logic [7:0] GSV_ROW_VAL_RST   = 8'hff;
  localparam logic [7:0] GSV_COL_VAL_RST   = 8'hff;
  localparam logic [7:0] GSV_PAIR_EN_RST   = 8'h00;

  // Column lines whose output stage is open-drain only
  localparam logic [7:0] GSV_COL_OD_ONLY   = 8'hf0;
  // Unmapped reads answer with this value
  localparam logic [7:0] GSV_UNMAPPED_DATA = 8'h00;

  // Register write or read request from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gsv_req_t;

  // Drive of one pin group: level and active-low output enable
  typedef struct packed {
    logic [7:0] lvl;
    logic [7:0] oe_n;
  } gsv_drive_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] row_dir;
    logic [7:0] col_dir;
    logic [7:0] row_mode;
    logic [7:0] col_mode;
    logic [7:0] row_sup;
    logic [7:0] col_sup;
    logic [7:0] row_val;
    logic [7:0] col_val;
    logic [7:0] pair_en;
    logic [7:0] rdata;
    logic       rvalid;
    gsv_drive_t row_drv;
    gsv_drive_t col_drv;
  } gsv_state_t;

endpackage

/* File: gsv_gpio_block.sv */
`timescale 1ns/1ps

module gsv_gpio_block
  import gsv_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Register port from the serial interface engine
  input  wire gsv_req_t   req_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  // Row pins
  input  wire logic [7:0] row_in_i,
  output logic [7:0]      row_out_o,
  output logic [7:0]      row_oe_n_o,
  output logic [7:0]      row_sup_sel_o,
  // Column pins
  input  wire logic [7:0] col_in_i,
  output logic [7:0]      col_out_o,
  output logic [7:0]      col_oe_n_o,
  output logic [7:0]      col_sup_sel_o
);

  gsv_state_t q;
  gsv_state_t next_q;

  // Address compare, shared by write decode and read mux
  function automatic logic hit(input gsv_req_t r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  // Pin stage: open-drain releases for high, push-pull drives both levels whenever drive is set
  function automatic logic [1:0] stage(input logic drive, input logic lvl,
                                       input logic push_pull);
    logic en;
    en = drive && (push_pull || !lvl);
    stage = {lvl && en, !en};
  endfunction

  // Register writes, read answers and pin drive
  always_comb begin
    logic [1:0] s;
    s = 2'b00;
    next_q = q;
    next_q.rvalid = req_i.rd;
    if (req_i.wr) begin
      if (hit(req_i, GSV_ROW_DIR_OFS)) next_q.row_dir = req_i.wdata;
      if (hit(req_i, GSV_COL_DIR_OFS)) next_q.col_dir = req_i.wdata;
      if (hit(req_i, GSV_ROW_MODE_OFS)) next_q.row_mode = req_i.wdata;
      // Upper column mode bits stay zero whatever is written
      if (hit(req_i, GSV_COL_MODE_OFS)) begin
        next_q.col_mode = req_i.wdata & ~GSV_COL_OD_ONLY;
      end
      if (hit(req_i, GSV_ROW_SUP_OFS)) next_q.row_sup = req_i.wdata;
      if (hit(req_i, GSV_COL_SUP_OFS)) next_q.col_sup = req_i.wdata;
      if (hit(req_i, GSV_ROW_VAL_OFS)) next_q.row_val = req_i.wdata;
      if (hit(req_i, GSV_COL_VAL_OFS)) next_q.col_val = req_i.wdata;
      if (hit(req_i, GSV_PAIR_EN_OFS)) next_q.pair_en = req_i.wdata;
    end
    // Read returns the stored value before any same-cycle write
    if (req_i.rd) begin
      unique case (1'b1)
        hit(req_i, GSV_ROW_DIR_OFS):  next_q.rdata = q.row_dir;
        hit(req_i, GSV_COL_DIR_OFS):  next_q.rdata = q.col_dir;
        hit(req_i, GSV_ROW_MODE_OFS): next_q.rdata = q.row_mode;
        hit(req_i, GSV_COL_MODE_OFS): next_q.rdata = q.col_mode;
        hit(req_i, GSV_ROW_SUP_OFS):  next_q.rdata = q.row_sup;
        hit(req_i, GSV_COL_SUP_OFS):  next_q.rdata = q.col_sup;
        hit(req_i, GSV_ROW_VAL_OFS):  next_q.rdata = q.row_val;
        hit(req_i, GSV_COL_VAL_OFS):  next_q.rdata = q.col_val;
        hit(req_i, GSV_PAIR_EN_OFS):  next_q.rdata = q.pair_en;
        default:                      next_q.rdata = GSV_UNMAPPED_DATA;
      endcase
    end
    // Pin drive is taken from the settled registers, one cycle behind writes
    for (int n = 0; n < 8; n++) begin
      if (q.pair_en[n]) begin
        // Translating pair: column output copies row, else row copies column
        if (q.col_dir[n]) begin
          s = stage(1'b1, row_in_i[n], q.col_mode[n]);
          {next_q.col_drv.lvl[n], next_q.col_drv.oe_n[n]} = s;
          {next_q.row_drv.lvl[n], next_q.row_drv.oe_n[n]} = 2'b01;
        end else begin
          s = stage(1'b1, col_in_i[n], q.row_mode[n]);
          {next_q.row_drv.lvl[n], next_q.row_drv.oe_n[n]} = s;
          {next_q.col_drv.lvl[n], next_q.col_drv.oe_n[n]} = 2'b01;
        end
      end else begin
        s = stage(q.row_dir[n], q.row_val[n], q.row_mode[n]);
        {next_q.row_drv.lvl[n], next_q.row_drv.oe_n[n]} = s;
        s = stage(q.col_dir[n], q.col_val[n], q.col_mode[n]);
        {next_q.col_drv.lvl[n], next_q.col_drv.oe_n[n]} = s;
      end
    end
  end

  // State register; drive resets to all pins released
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      q.row_dir  <= GSV_ROW_DIR_RST;
      q.col_dir  <= GSV_COL_DIR_RST;
      q.row_mode <= GSV_ROW_MODE_RST;
      q.col_mode <= GSV_COL_MODE_RST;
      q.row_sup  <= GSV_ROW_SUP_RST;
      q.col_sup  <= GSV_COL_SUP_RST;
      q.row_val  <= GSV_ROW_VAL_RST;
      q.col_val  <= GSV_COL_VAL_RST;
      q.pair_en  <= GSV_PAIR_EN_RST;
      q.rdata    <= GSV_UNMAPPED_DATA;
      q.rvalid   <= 1'b0;
      q.row_drv  <= '{lvl: 8'h00, oe_n: 8'hff};
      q.col_drv  <= '{lvl: 8'h00, oe_n: 8'hff};
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o       = q.rdata;
  assign rvalid_o      = q.rvalid;
  assign row_out_o     = q.row_drv.lvl;
  assign row_oe_n_o    = q.row_drv.oe_n;
  assign row_sup_sel_o = q.row_sup;
  assign col_out_o     = q.col_drv.lvl;
  assign col_oe_n_o    = q.col_drv.oe_n;
  assign col_sup_sel_o = q.col_sup;

  // All checks run on the system clock and sleep through reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr(logic [7:0] ofs);
    req_i.wr && req_i.addr == ofs;
  endsequence

  sequence s_rd(logic [7:0] ofs);
    req_i.rd && req_i.addr == ofs && !req_i.wr;
  endsequence

  // Reads outside the register map, above the last or below the first offset
  sequence s_rd_unmapped;
    req_i.rd && (req_i.addr > GSV_PAIR_EN_OFS || req_i.addr < GSV_ROW_DIR_OFS);
  endsequence

  // Pair 1 with its column as input: the row copies the column
  sequence s_col_to_row;
    q.pair_en[1] && !q.col_dir[1] && q.row_mode[1];
  endsequence

  // Supply selects follow a write on the next cycle
  a_row_sup_write: assert property (s_wr(GSV_ROW_SUP_OFS)
    |=> row_sup_sel_o == $past(req_i.wdata))
    else $error("row supply select not updated");
  a_col_sup_write: assert property (s_wr(GSV_COL_SUP_OFS)
    |=> col_sup_sel_o == $past(req_i.wdata))
    else $error("column supply select not updated");

  // Output values reach the pins one cycle after the registers hold them
  a_row_val_drive: assert property (q.row_dir[2] && q.row_mode[2] && !q.pair_en[2]
    |=> row_oe_n_o[2] == 1'b0 && row_out_o[2] == $past(q.row_val[2]))
    else $error("row output value not driven");
  a_col_val_drive: assert property (q.col_dir[1] && q.col_mode[1] && !q.pair_en[1]
    |=> col_oe_n_o[1] == 1'b0 && col_out_o[1] == $past(q.col_val[1]))
    else $error("column output value not driven");

  // Open-drain columns release for high but still pull low
  a_col_od_release: assert property (q.col_dir[6] && q.col_val[6] && !q.pair_en[6]
    |=> col_oe_n_o[6] && !col_out_o[6])
    else $error("open-drain column driven high");
  a_col_od_low: assert property (q.col_dir[7] && !q.col_val[7] && !q.pair_en[7]
    |=> !col_oe_n_o[7] && !col_out_o[7])
    else $error("open-drain column not pulled low");

  // A write and a read back to back see the new value
  a_pair_en_write: assert property (s_wr(GSV_PAIR_EN_OFS) ##1 s_rd(GSV_PAIR_EN_OFS)
    |=> rvalid_o && rdata_o == $past(req_i.wdata, 2))
    else $error("pair enable not stored");

  // Translator: the column direction bit picks which side drives
  a_pair_direction: assert property (q.pair_en[0] && q.col_dir[0] && q.col_mode[0]
    |=> col_oe_n_o[0] == 1'b0 && col_out_o[0] == $past(row_in_i[0]) && row_oe_n_o[0])
    else $error("translator direction wrong");
  a_row_from_col: assert property (s_col_to_row
    |=> row_oe_n_o[1] == 1'b0 && row_out_o[1] == $past(col_in_i[1]) && col_oe_n_o[1])
    else $error("column-to-row translation wrong");
  a_pair_col_release: assert property (q.pair_en[7] && !q.col_dir[7] |=> col_oe_n_o[7])
    else $error("translating input column driven");

  // Lines that are inputs and not translating stay released
  a_col_dir_input: assert property (!q.col_dir[0] && !q.pair_en[0] |=> col_oe_n_o[0])
    else $error("input column driven");
  a_row_dir_input: assert property (!q.row_dir[5] && !q.pair_en[5] |=> row_oe_n_o[5])
    else $error("input row driven");

  // Upper column mode bits are locked, the lower ones follow writes
  a_od_mode_locked: assert property (s_wr(GSV_COL_MODE_OFS)
    |=> q.col_mode[7:4] == 4'h0 ##1 q.col_mode[7:4] == 4'h0)
    else $error("open-drain-only mode bits written");
  a_col_mode_low: assert property (s_wr(GSV_COL_MODE_OFS)
    |=> q.col_mode[3:0] == $past(req_i.wdata[3:0]))
    else $error("column mode low bits not stored");

  // Read answers: one-cycle valid, data stands until the next read
  a_read_back: assert property (s_rd(GSV_ROW_VAL_OFS)
    |=> rvalid_o && rdata_o == $past(q.row_val))
    else $error("read back mismatch");
  a_rvalid_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  a_rvalid_pulse: assert property (!req_i.rd |=> !rvalid_o)
    else $error("answer without a read");
  a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_unmapped_read: assert property (s_rd_unmapped |=> rdata_o == GSV_UNMAPPED_DATA)
    else $error("unmapped read not zero");

endmodule

/* File: gsv_pin_model.sv */
`timescale 1ns/1ps

// Outside world of the pins: pull-ups on all lines, optional outside drivers
module gsv_pin_model (
  // Design side
  input  wire logic [7:0] row_out_i,
  input  wire logic [7:0] row_oe_n_i,
  input  wire logic [7:0] col_out_i,
  input  wire logic [7:0] col_oe_n_i,
  // Outside drivers, enable 1 = driving
  input  wire logic [7:0] row_ext_i,
  input  wire logic [7:0] row_ext_en_i,
  input  wire logic [7:0] col_ext_i,
  input  wire logic [7:0] col_ext_en_i,
  // Resolved wire levels
  output logic [7:0]      row_lvl_o,
  output logic [7:0]      col_lvl_o
);
  // Released and undriven lines rise through the pull-up
  assign row_lvl_o = ~row_oe_n_i & row_out_i
                   | row_oe_n_i & (row_ext_en_i & row_ext_i | ~row_ext_en_i);
  assign col_lvl_o = ~col_oe_n_i & col_out_i
                   | col_oe_n_i & (col_ext_en_i & col_ext_i | ~col_ext_en_i);
endmodule

/* File: tb_gpio_supply_value_level_shift.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_gpio_supply_value_level_shift
  import gsv_pkg::*;
;
  logic       sys_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  gsv_req_t   req       = '0;
  logic [7:0] rdata, row_out, row_oe_n, row_sup, col_out, col_oe_n, col_sup, row_lvl, col_lvl;
  logic       rvalid;
  logic [7:0] row_ext = 8'h00, row_ext_en = 8'h00, col_ext = 8'h00, col_ext_en = 8'h00;
  int         err_count = 0;
  int         check_count = 0;
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};

  // Clock, 20 ns period
  always #10 sys_clk_i = ~sys_clk_i;

  gsv_gpio_block i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .row_in_i(row_lvl), .row_out_o(row_out),
    .row_oe_n_o(row_oe_n), .row_sup_sel_o(row_sup), .col_in_i(col_lvl),
    .col_out_o(col_out), .col_oe_n_o(col_oe_n), .col_sup_sel_o(col_sup));

  gsv_pin_model i_pins (.row_out_i(row_out), .row_oe_n_i(row_oe_n), .col_out_i(col_out),
    .col_oe_n_i(col_oe_n), .row_ext_i(row_ext), .row_ext_en_i(row_ext_en),
    .col_ext_i(col_ext), .col_ext_en_i(col_ext_en), .row_lvl_o(row_lvl), .col_lvl_o(col_lvl));

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i) req <= {2'b10, a, d};
    @(posedge sys_clk_i) req <= '0;
  endtask

  // Read strobe; answer is looked at in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge sys_clk_i) req <= {2'b01, a, 8'h00};
    @(posedge sys_clk_i) req <= '0;
    #1 `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", ex, rdata)
  endtask

  // Pins follow a write two edges later
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 9; i++) begin
      rd(8'h34 + 8'(i), rst_tab[i]);
    end
    `CHK("col_sup", 8'h00, col_sup)
    $display("reset test done");
  endtask

  task automatic t_supply();
    wr(8'h38, 8'ha5);
    wr(8'h39, 8'h3c);
    settle();
    `CHK("row_sup", 8'ha5, row_sup)
    `CHK("col_sup", 8'h3c, col_sup)
    rd(8'h38, 8'ha5);
    rd(8'h39, 8'h3c);
    $display("supply test done");
  endtask

  task automatic t_values();
    wr(8'h34, 8'hff);
    wr(8'h3a, 8'h5a);
    wr(8'h37, 8'hff);
    rd(8'h37, 8'h0f);
    wr(8'h35, 8'hff);
    wr(8'h3b, 8'h3c);
    settle();
    `CHK("row_oe_n", 8'h00, row_oe_n)
    `CHK("row_lvl", 8'h5a, row_lvl)
    `CHK("col_oe_n", 8'h30, col_oe_n)
    `CHK("col_lvl", 8'h3c, col_lvl)
    $display("value test done");
  endtask

  // Pair 0 row-to-column, pair 1 column-to-row, both outside levels
  task automatic t_pairs();
    logic v;
    wr(8'h3c, 8'h03);
    wr(8'h35, 8'h01);
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      @(posedge sys_clk_i) begin
        row_ext <= {8{v}};
        col_ext <= {8{v}};
        row_ext_en <= 8'h01;
        col_ext_en <= 8'h02;
      end
      settle();
      `CHK("column_line_0", v, col_lvl[0])
      `CHK("row_line_1", v, row_lvl[1])
      `CHK("row_line_0_oe_n", 1'b1, row_oe_n[0])
      `CHK("column_line_1_oe_n", 1'b1, col_oe_n[1])
    end
    rd(8'h3c, 8'h03);
    $display("pair test done");
  endtask

  // Unmapped place: write ignored, read gives zero
  task automatic t_unmapped();
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    @(posedge sys_clk_i) #1 `CHK("rvalid_fall", 1'b0, rvalid)
    // Write then read of the same register on consecutive edges
    @(posedge sys_clk_i) req <= {2'b10, GSV_PAIR_EN_OFS, 8'h81};
    @(posedge sys_clk_i) req <= {2'b01, GSV_PAIR_EN_OFS, 8'h00};
    @(posedge sys_clk_i) req <= '0;
    #1 `CHK("pair_b2b", 8'h81, rdata)
    $display("unmapped test done");
  endtask

  // Reset in mid-run brings back reset values and releases the pins
  task automatic t_mid_reset();
    wr(8'h38, 8'hff);
    @(posedge sys_clk_i) rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1 `CHK("row_sup_rst", 8'h00, row_sup)
    `CHK("col_oe_n_rst", 8'hff, col_oe_n)
    rd(8'h3c, 8'h00);
    rd(8'h38, 8'h00);
    $display("mid-run reset test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need under a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_supply();
    t_values();
    t_pairs();
    t_unmapped();
    t_mid_reset();
    complete_run();
  end
endmodule
